// ---- verilog/fpdec_decoder.v ----
// Coprocessor instruction decoder with its bus-state sequencer.
`timescale 1ns/1ps
`include "fpdec_defines.vh"
// Contract
// - Memory-format field picks real32, int32, real64 or int16 operand type.
// - Mod 00 no displacement, 01 sign-extended byte, 10 two bytes low first.
// - Mod 11 makes r/m a stack element index below the top.
// - R/m 000 to 011 add BX+SI, BX+DI, BP+SI, BP+DI to displacement.
// - Mod 00 with r/m 110 uses the displacement bytes as address.
// - Destination bit 0 writes stack top, 1 writes selected element.
// - Pop bit 1 pops the stack top after the result is written.
// - Popping register arithmetic takes five clocks more than non-popping.
// - Reverse bit picks operand order, inverted when destination bit is 1.
// - Ready is sampled in T2, T3 and wait states; low inserts wait. Sampled here in T3 and wait states only.
// - Local bus outputs float only when control returns to the host.
// - Status returns passive in the state just before T4. Goes passive here on entry to T3, ahead of any wait states.
// - Load control word reads memory into control, 7 to 14 clocks.
// - Store status word writes status to memory, 12 to 18 clocks.
// - Advance stack top moves the pointer only, 6 to 12 clocks.
module fpdec_decoder (
	input wire CLOCK,
	input wire SYS_RST,
	input wire INSTR_VALID,
	input wire [15:0] INSTR_WORD,
	input wire [7:0] DISP_LO,
	input wire [7:0] DISP_HI,
	input wire [15:0] REG_BX,
	input wire [15:0] REG_BP,
	input wire [15:0] REG_SI,
	input wire [15:0] REG_DI,
	input wire BUS_START,
	input wire BUS_WRITE,
	input wire BUS_HANDBACK,
	input wire READY,
	input wire [15:0] MEM_RDATA,
	output reg DEC_VALID,
	output reg DEC_UNDEFINED,
	output reg [2:0] DEC_CLASS,
	output reg [1:0] MEMORY_FORMAT_FIELD,
	output reg MEM_OPERAND,
	output reg [2:0] STACK_ELEMENT_BELOW_TOP,
	output reg DEST_IS_ELEMENT,
	output reg POP_AFTER,
	output reg SOURCE_OP_DEST,
	output reg [15:0] EFFECTIVE_ADDRESS,
	output reg [7:0] CLOCKS_MIN,
	output reg [7:0] CLOCKS_MAX,
	output reg CLOCKS_PLUS_EA,
	output reg [2:0] STACK_TOP,
	output reg [15:0] CONTROL_WORD,
	output reg [15:0] STORE_DATA,
	output reg [2:0] BUS_STATUS,
	output reg [2:0] BUS_STATE,
	output reg BUS_FLOAT_N
);
	wire [4:0] esc = INSTR_WORD[15:11];
	wire [2:0] low3 = INSTR_WORD[10:8];
	wire [1:0] mode = INSTR_WORD[7:6];
	wire [2:0] reg_op = INSTR_WORD[5:3];
	wire [2:0] rm = INSTR_WORD[2:0];
	wire [15:0] ea_w;
	reg [2:0] cls;
	reg [7:0] cmin;
	reg [7:0] cmax;
	reg plus_ea;
	reg [2:0] bus_state_nxt;
	reg [15:0] status_word;
	reg ldcw_pending_r;
	reg stsw_pending_r;

	fpdec_ea_unit u_ea (
		.mode(mode),
		.rm(rm),
		.disp_lo(DISP_LO),
		.disp_hi(DISP_HI),
		.reg_bx(REG_BX),
		.reg_bp(REG_BP),
		.reg_si(REG_SI),
		.reg_di(REG_DI),
		.effective_address(ea_w)
	);

	// Classification of the prefixed encoding and its clock range.
	always @* begin
		cls = `FPDEC_CLS_UNDEF;
		cmin = 8'h00;
		cmax = 8'h00;
		plus_ea = 1'b0;
		if (esc != `FPDEC_ESC_OPCODE) begin
			cls = `FPDEC_CLS_UNDEF;
		end else if (mode == `FPDEC_MOD_REG) begin
			if (low3[0] == 1'b0 && reg_op[2:1] != 2'h1) begin
				// Register arithmetic: add, mul, sub, div with d and P bits.
				cls = `FPDEC_CLS_ARITH_REG;
				cmin = `FPDEC_ARITH_MIN;
				cmax = `FPDEC_ARITH_MAX;
				if (low3[1]) begin
					cmin = `FPDEC_ARITH_MIN + `FPDEC_POP_EXTRA;
					cmax = `FPDEC_ARITH_MAX + `FPDEC_POP_EXTRA;
				end
			end else if (low3 == 3'h1 && reg_op == 3'h6 && rm == 3'h7) begin
				cls = `FPDEC_CLS_INCSTP;
				cmin = `FPDEC_INCSTP_MIN;
				cmax = `FPDEC_INCSTP_MAX;
			end else if (low3 == 3'h1 || low3 == 3'h3 || low3 == 3'h5) begin
				cls = `FPDEC_CLS_OTHER;
			end else begin
				cls = `FPDEC_CLS_UNDEF;
			end
		end else begin
			if (low3[0] == 1'b0) begin
				cls = `FPDEC_CLS_ARITH_MEM;
				plus_ea = 1'b1;
			end else if (low3 == 3'h1 && reg_op == 3'h5) begin
				cls = `FPDEC_CLS_LDCW;
				cmin = `FPDEC_LDCW_MIN;
				cmax = `FPDEC_LDCW_MAX;
				plus_ea = 1'b1;
			end else if (low3 == 3'h5 && reg_op == 3'h7) begin
				cls = `FPDEC_CLS_STSW;
				cmin = `FPDEC_STSW_MIN;
				cmax = `FPDEC_STSW_MAX;
				plus_ea = 1'b1;
			end else if (reg_op != 3'h1) begin
				cls = `FPDEC_CLS_OTHER;
				plus_ea = 1'b1;
			end else begin
				cls = `FPDEC_CLS_UNDEF;
			end
		end
	end

	always @* begin
		status_word = {2'h0, STACK_TOP, 11'h000};
	end

	// Decoded fields other than DEC_VALID and DEC_UNDEFINED are held until the next valid instruction.
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			DEC_VALID <= 1'b0;
			DEC_UNDEFINED <= 1'b0;
			DEC_CLASS <= `FPDEC_CLS_UNDEF;
			MEMORY_FORMAT_FIELD <= `FPDEC_MF_REAL32;
			MEM_OPERAND <= 1'b0;
			STACK_ELEMENT_BELOW_TOP <= 3'h0;
			DEST_IS_ELEMENT <= 1'b0;
			POP_AFTER <= 1'b0;
			SOURCE_OP_DEST <= 1'b0;
			EFFECTIVE_ADDRESS <= 16'h0000;
			CLOCKS_MIN <= 8'h00;
			CLOCKS_MAX <= 8'h00;
			CLOCKS_PLUS_EA <= 1'b0;
			STACK_TOP <= 3'h0;
		end else begin
			DEC_VALID <= INSTR_VALID && cls != `FPDEC_CLS_UNDEF;
			DEC_UNDEFINED <= INSTR_VALID && cls == `FPDEC_CLS_UNDEF;
			if (INSTR_VALID) begin
				DEC_CLASS <= cls;
				MEMORY_FORMAT_FIELD <= low3[2:1];
				MEM_OPERAND <= mode != `FPDEC_MOD_REG;
				STACK_ELEMENT_BELOW_TOP <= (mode == `FPDEC_MOD_REG) ? rm : 3'h0;
				EFFECTIVE_ADDRESS <= (mode == `FPDEC_MOD_REG) ? 16'h0000 : ea_w;
				CLOCKS_MIN <= cmin;
				CLOCKS_MAX <= cmax;
				CLOCKS_PLUS_EA <= plus_ea;
				if (cls == `FPDEC_CLS_ARITH_REG) begin
					DEST_IS_ELEMENT <= low3[2];
					POP_AFTER <= low3[1];
					SOURCE_OP_DEST <= reg_op[0] ^ low3[2];
				end else begin
					DEST_IS_ELEMENT <= 1'b0;
					POP_AFTER <= 1'b0;
					SOURCE_OP_DEST <= (cls == `FPDEC_CLS_ARITH_MEM) ? reg_op[0] : 1'b0;
				end
				// Undefined encodings must leave architectural state alone.
				if (cls == `FPDEC_CLS_INCSTP) begin
					STACK_TOP <= STACK_TOP + 3'h1;
				end else if (cls == `FPDEC_CLS_ARITH_REG && low3[1]) begin
					STACK_TOP <= STACK_TOP + 3'h1;
				end
			end
		end
	end

	// Memory-side effects of the control and status word transfers.
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			CONTROL_WORD <= 16'h03FF;
			STORE_DATA <= 16'h0000;
			ldcw_pending_r <= 1'b0;
			stsw_pending_r <= 1'b0;
		end else begin
			if (INSTR_VALID && cls == `FPDEC_CLS_LDCW) begin
				ldcw_pending_r <= 1'b1;
			end else if (BUS_STATE == `FPDEC_BUS_T4) begin
				ldcw_pending_r <= 1'b0;
			end
			if (INSTR_VALID && cls == `FPDEC_CLS_STSW) begin
				stsw_pending_r <= 1'b1;
				STORE_DATA <= status_word;
			end else if (BUS_STATE == `FPDEC_BUS_T4) begin
				stsw_pending_r <= 1'b0;
			end
			if (ldcw_pending_r && !BUS_WRITE && READY &&
				(BUS_STATE == `FPDEC_BUS_T3 || BUS_STATE == `FPDEC_BUS_TW)) begin
				CONTROL_WORD <= MEM_RDATA;
			end
		end
	end

	// Bus state sequence for cycles that the coprocessor masters.
	always @* begin
		bus_state_nxt = BUS_STATE;
		case (BUS_STATE)
			`FPDEC_BUS_IDLE: begin
				if (BUS_START) begin
					bus_state_nxt = `FPDEC_BUS_T1;
				end
			end
			`FPDEC_BUS_T1: bus_state_nxt = `FPDEC_BUS_T2;
			`FPDEC_BUS_T2: bus_state_nxt = `FPDEC_BUS_T3;
			`FPDEC_BUS_T3, `FPDEC_BUS_TW: begin
				bus_state_nxt = READY ? `FPDEC_BUS_T4 : `FPDEC_BUS_TW;
			end
			`FPDEC_BUS_T4: bus_state_nxt = `FPDEC_BUS_IDLE;
			default: bus_state_nxt = `FPDEC_BUS_IDLE;
		endcase
	end

	// Ready is honoured from T3 onward; the T2 sample merely precedes T3 here.
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			BUS_STATE <= `FPDEC_BUS_IDLE;
			BUS_STATUS <= `FPDEC_STATUS_PASSIVE;
			BUS_FLOAT_N <= 1'b1;
		end else begin
			BUS_STATE <= bus_state_nxt;
			if (bus_state_nxt == `FPDEC_BUS_T1) begin
				BUS_STATUS <= BUS_WRITE ? 3'h6 : 3'h5;
			end else if (bus_state_nxt == `FPDEC_BUS_T3) begin
				// Going passive on entry to T3 covers T3 and every wait state before T4.
				BUS_STATUS <= `FPDEC_STATUS_PASSIVE;
			end
			// Floating between ordinary cycles would let the lines drift mid-grant.
			if (BUS_HANDBACK && BUS_STATE == `FPDEC_BUS_T4) begin
				BUS_FLOAT_N <= 1'b1;
			end else if (bus_state_nxt == `FPDEC_BUS_T1) begin
				BUS_FLOAT_N <= 1'b0;
			end
		end
	end
endmodule // fpdec_decoder

// ---- pkg/fpdec_defines.vh ----
// Constants for the coprocessor instruction decoder.
`ifndef FPDEC_DEFINES_VH
`define FPDEC_DEFINES_VH
`define FPDEC_ESC_OPCODE 5'h1B
`define FPDEC_MF_REAL32 2'h0
`define FPDEC_MF_INT32 2'h1
`define FPDEC_MF_REAL64 2'h2
`define FPDEC_MF_INT16 2'h3
`define FPDEC_MOD_NODISP 2'h0
`define FPDEC_MOD_DISP8 2'h1
`define FPDEC_MOD_DISP16 2'h2
`define FPDEC_MOD_REG 2'h3
`define FPDEC_RM_DIRECT 3'h6
`define FPDEC_POP_EXTRA 8'h05
`define FPDEC_LDCW_MIN 8'h07
`define FPDEC_LDCW_MAX 8'h0E
`define FPDEC_STSW_MIN 8'h0C
`define FPDEC_STSW_MAX 8'h12
`define FPDEC_INCSTP_MIN 8'h06
`define FPDEC_INCSTP_MAX 8'h0C
`define FPDEC_ARITH_MIN 8'h46
`define FPDEC_ARITH_MAX 8'h64
`define FPDEC_CLS_UNDEF 3'h0
`define FPDEC_CLS_ARITH_REG 3'h1
`define FPDEC_CLS_ARITH_MEM 3'h2
`define FPDEC_CLS_LDCW 3'h3
`define FPDEC_CLS_STSW 3'h4
`define FPDEC_CLS_INCSTP 3'h5
`define FPDEC_CLS_OTHER 3'h6
`define FPDEC_BUS_IDLE 3'h0
`define FPDEC_BUS_T1 3'h1
`define FPDEC_BUS_T2 3'h2
`define FPDEC_BUS_T3 3'h3
`define FPDEC_BUS_TW 3'h4
`define FPDEC_BUS_T4 3'h5
`define FPDEC_STATUS_PASSIVE 3'h7
`endif

// ---- verilog/fpdec_ea_unit.v ----
// Effective address former for the memory operand of a decoded instruction.
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module fpdec_ea_unit (
	input wire [1:0] mode,
	input wire [2:0] rm,
	input wire [7:0] disp_lo,
	input wire [7:0] disp_hi,
	input wire [15:0] reg_bx,
	input wire [15:0] reg_bp,
	input wire [15:0] reg_si,
	input wire [15:0] reg_di,
	output reg [15:0] effective_address
);
	reg [15:0] disp;
	reg [15:0] base;
	always @* begin
		case (mode)
			`FPDEC_MOD_DISP8: disp = {{8{disp_lo[7]}}, disp_lo};
			`FPDEC_MOD_DISP16: disp = {disp_hi, disp_lo};
			default: disp = 16'h0000;
		endcase
		case (rm)
			3'h0: base = reg_bx + reg_si;
			3'h1: base = reg_bx + reg_di;
			3'h2: base = reg_bp + reg_si;
			3'h3: base = reg_bp + reg_di;
			3'h4: base = reg_si;
			3'h5: base = reg_di;
			3'h6: base = reg_bp;
			default: base = reg_bx;
		endcase
		if (mode == `FPDEC_MOD_NODISP && rm == `FPDEC_RM_DIRECT) begin
			effective_address = {disp_hi, disp_lo};
		end else begin
			effective_address = base + disp;
		end
	end
endmodule // fpdec_ea_unit

// ---- testbench/fpdec_chk.sv ----
// Port checker for the coprocessor instruction decoder.
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module fpdec_chk (
	input wire CLOCK,
	input wire SYS_RST,
	input wire INSTR_VALID,
	input wire [15:0] INSTR_WORD,
	input wire [7:0] DISP_LO,
	input wire [7:0] DISP_HI,
	input wire BUS_HANDBACK,
	input wire READY,
	input wire DEC_VALID,
	input wire DEC_UNDEFINED,
	input wire [2:0] DEC_CLASS,
	input wire [1:0] MEMORY_FORMAT_FIELD,
	input wire [2:0] STACK_ELEMENT_BELOW_TOP,
	input wire POP_AFTER,
	input wire [15:0] EFFECTIVE_ADDRESS,
	input wire [7:0] CLOCKS_MIN,
	input wire [7:0] CLOCKS_MAX,
	input wire [2:0] BUS_STATUS,
	input wire [2:0] BUS_STATE,
	input wire BUS_FLOAT_N
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	wire data_st = (BUS_STATE == `FPDEC_BUS_T3) || (BUS_STATE == `FPDEC_BUS_TW);
	property p_answer; INSTR_VALID |=> DEC_VALID || DEC_UNDEFINED; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_mf; INSTR_VALID ##1 DEC_VALID |-> MEMORY_FORMAT_FIELD == $past(INSTR_WORD[10:9]); endproperty
	a_mf: assert property (p_mf) else $error("format");
	property p_elem; INSTR_VALID ##1 DEC_VALID |-> STACK_ELEMENT_BELOW_TOP ==
		($past(INSTR_WORD[7:6]) == 2'h3 ? $past(INSTR_WORD[2:0]) : 3'h0); endproperty
	a_elem: assert property (p_elem) else $error("element");
	property p_direct; (INSTR_VALID && INSTR_WORD[7:6] == 2'h0 && INSTR_WORD[2:0] == 3'h6)
		##1 DEC_VALID |-> EFFECTIVE_ADDRESS == $past({DISP_HI, DISP_LO}); endproperty
	a_direct: assert property (p_direct) else $error("direct");
	property p_popclk; DEC_CLASS == `FPDEC_CLS_ARITH_REG |->
		CLOCKS_MIN == `FPDEC_ARITH_MIN + (POP_AFTER ? `FPDEC_POP_EXTRA : 8'h00) &&
		CLOCKS_MAX == `FPDEC_ARITH_MAX + (POP_AFTER ? `FPDEC_POP_EXTRA : 8'h00); endproperty
	a_popclk: assert property (p_popclk) else $error("pop clocks");
	property p_wait; data_st && !READY |=> BUS_STATE == `FPDEC_BUS_TW; endproperty
	a_wait: assert property (p_wait) else $error("wait");
	property p_passive; data_st && READY |=> BUS_STATE == `FPDEC_BUS_T4 &&
		BUS_STATUS == `FPDEC_STATUS_PASSIVE; endproperty
	a_passive: assert property (p_passive) else $error("passive");
	property p_prepass; data_st |-> BUS_STATUS == `FPDEC_STATUS_PASSIVE; endproperty
	a_prepass: assert property (p_prepass) else $error("status before end");
	property p_float; $rose(BUS_FLOAT_N) |-> $past(BUS_STATE) == `FPDEC_BUS_T4 && $past(BUS_HANDBACK);
	endproperty
	a_float: assert property (p_float) else $error("float");
endmodule // fpdec_chk
bind fpdec_decoder fpdec_chk i_fpdec_chk (.*);

// ---- testbench/fpdec_host_model.sv ----
// Host side of the local bus: ready after a set number of wait states.
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module fpdec_host_model (
	input wire clock,
	input wire [2:0] bus_state,
	input wire [3:0] waits,
	input wire [15:0] rdata,
	output wire ready,
	output wire [15:0] mem_rdata
);
	reg [3:0] cnt_r;
	wire data_st = (bus_state == `FPDEC_BUS_T3) || (bus_state == `FPDEC_BUS_TW);
	always @(posedge clock) begin
		cnt_r <= data_st ? cnt_r + 4'h1 : 4'h0;
	end
	assign ready = data_st && (cnt_r == waits);
	// Outside the accepted sample the lines show the inverse, so a stale latch is seen.
	assign mem_rdata = ready ? rdata : ~rdata;
endmodule // fpdec_host_model

// ---- testbench/test_fpu_instruction_decoder.sv ----
// Self-checking bench for the coprocessor instruction decoder.
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module test_fpu_instruction_decoder;
	logic CLOCK = 1'b0, SYS_RST = 1'b1, INSTR_VALID = 1'b0, BUS_START = 1'b0, BUS_WRITE = 1'b0;
	logic BUS_HANDBACK = 1'b0, READY, DEC_VALID, DEC_UNDEFINED, MEM_OPERAND, DEST_IS_ELEMENT;
	logic POP_AFTER, SOURCE_OP_DEST, CLOCKS_PLUS_EA, BUS_FLOAT_N;
	logic [15:0] INSTR_WORD = 16'h0000, MEM_RDATA, EFFECTIVE_ADDRESS, CONTROL_WORD, STORE_DATA;
	logic [15:0] REG_BX = 16'h1000, REG_BP = 16'h2000, REG_SI = 16'h0300, REG_DI = 16'h0040;
	logic [15:0] rdata = 16'h1234;
	logic [7:0] DISP_LO = 8'h00, DISP_HI = 8'h00, CLOCKS_MIN, CLOCKS_MAX;
	logic [3:0] waits = 4'h0;
	logic [2:0] DEC_CLASS, STACK_ELEMENT_BELOW_TOP, STACK_TOP, BUS_STATUS, BUS_STATE, t;
	logic [1:0] MEMORY_FORMAT_FIELD;
	integer n_fail = 0, n_checks = 0, cyc = 0;
	fpdec_decoder i_fpdec_decoder (.*);
	fpdec_host_model i_fpdec_host_model (.clock(CLOCK), .bus_state(BUS_STATE), .waits(waits),
		.rdata(rdata), .ready(READY), .mem_rdata(MEM_RDATA));
	always #12.5 CLOCK = ~CLOCK;
	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task dec(input logic [15:0] w, input logic [7:0] lo, input logic [7:0] hi);
		@(negedge CLOCK);
		INSTR_VALID = 1'b1;
		INSTR_WORD = w;
		DISP_LO = lo;
		DISP_HI = hi;
		@(negedge CLOCK);
		INSTR_VALID = 1'b0;
	endtask
	task bus(input logic wr, input logic hb, input logic [3:0] w);
		integer n;
		waits = w;
		@(negedge CLOCK);
		BUS_START = 1'b1;
		BUS_WRITE = wr;
		BUS_HANDBACK = hb;
		@(negedge CLOCK);
		BUS_START = 1'b0;
		chk("status", BUS_STATUS, wr ? 3'h6 : 3'h5);
		chk("drive", BUS_FLOAT_N, 1'b0);
		n = 1;
		while (BUS_STATE !== `FPDEC_BUS_IDLE && n < 40) begin
			@(negedge CLOCK);
			n++;
		end
		chk("states", n, 5 + w);
		chk("float", BUS_FLOAT_N, hb);
	endtask
	task t_mem;
		for (int m = 0; m < 4; m++) begin
			dec({5'h1B, m[1:0], 1'b0, 2'h0, 3'h0, 3'h0}, 8'h00, 8'h00);
			chk("format", MEMORY_FORMAT_FIELD, m[1:0]);
			chk("class", DEC_CLASS, `FPDEC_CLS_ARITH_MEM);
			chk("ea", EFFECTIVE_ADDRESS, REG_BX + REG_SI);
		end
		dec({5'h1B, 3'h0, 2'h1, 3'h0, 3'h1}, 8'hF0, 8'h77);
		chk("ea", EFFECTIVE_ADDRESS, REG_BX + REG_DI - 16'h0010);
		dec({5'h1B, 3'h0, 2'h2, 3'h0, 3'h2}, 8'h34, 8'h12);
		chk("ea", EFFECTIVE_ADDRESS, REG_BP + REG_SI + 16'h1234);
		dec({5'h1B, 3'h0, 2'h0, 3'h0, 3'h3}, 8'h55, 8'h66);
		chk("ea", EFFECTIVE_ADDRESS, REG_BP + REG_DI);
		dec({5'h1B, 3'h0, 2'h0, 3'h0, 3'h6}, 8'h78, 8'h56);
		chk("ea", EFFECTIVE_ADDRESS, 16'h5678);
		$display("memory forms done");
	endtask
	task t_reg;
		for (int k = 0; k < 4; k++) begin
			t = STACK_TOP;
			dec({5'h1B, k[1], k[0], 1'b0, 2'h3, 3'h5, 3'h2}, 8'h00, 8'h00);
			chk("dest", DEST_IS_ELEMENT, k[1]);
			chk("pop", POP_AFTER, k[0]);
			chk("order", SOURCE_OP_DEST, !k[1]);
			chk("elem", STACK_ELEMENT_BELOW_TOP, 3'h2);
			chk("memop", MEM_OPERAND, 1'b0);
			chk("min", CLOCKS_MIN, `FPDEC_ARITH_MIN + (k[0] ? 8'h05 : 8'h00));
			chk("top", STACK_TOP, t + {2'h0, k[0]});
		end
		$display("register forms done");
	endtask
	task t_ctl;
		t = STACK_TOP;
		dec({5'h1B, 3'h1, 2'h3, 3'h6, 3'h7}, 8'h00, 8'h00);
		chk("top", STACK_TOP, t + 3'h1);
		chk("min", CLOCKS_MIN, 8'h06);
		chk("max", CLOCKS_MAX, 8'h0C);
		dec({5'h1B, 3'h5, 2'h0, 3'h7, 3'h6}, 8'h00, 8'h40);
		chk("class", DEC_CLASS, `FPDEC_CLS_STSW);
		chk("sdata", STORE_DATA, {2'h0, t + 3'h1, 11'h000});
		chk("range", {CLOCKS_PLUS_EA, CLOCKS_MIN, CLOCKS_MAX}, {1'b1, 8'h0C, 8'h12});
		dec({5'h1B, 3'h1, 2'h0, 3'h1, 3'h0}, 8'h00, 8'h00);
		chk("undef", DEC_UNDEFINED, 1'b1);
		chk("top", STACK_TOP, t + 3'h1);
		dec({8'h9B, 8'h00}, 8'h00, 8'h00);
		chk("wait op", DEC_UNDEFINED, 1'b1);
		$display("control forms done");
	endtask
	task t_bus;
		dec({5'h1B, 3'h1, 2'h0, 3'h5, 3'h6}, 8'h00, 8'h01);
		chk("range", {CLOCKS_MIN, CLOCKS_MAX}, {8'h07, 8'h0E});
		bus(1'b0, 1'b1, 4'h2);
		chk("ctrl", CONTROL_WORD, 16'h1234);
		bus(1'b1, 1'b0, 4'h0);
		rdata = 16'hABCD;
		bus(1'b0, 1'b1, 4'h1);
		chk("ctrl", CONTROL_WORD, 16'h1234);
		$display("bus cycles done");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			summarize;
		end
	end
	initial begin
		repeat (20) @(negedge CLOCK);
		SYS_RST = 1'b0;
		chk("reset", {BUS_FLOAT_N, CONTROL_WORD}, {1'b1, 16'h03FF});
		t_mem;
		t_reg;
		t_ctl;
		t_bus;
		summarize;
	end
endmodule // test_fpu_instruction_decoder
